// File: include/rsmc_consts.svh
// constants of the remote spi master configuration block: offsets, fields, resets, timing
// assumes an 8-bit register port and a 50 MHz system clock
`ifndef RSMC_CONSTS_SVH
`define RSMC_CONSTS_SVH

// ============================================================
// register offsets
`define RSMC_ADDR_TIMING1 8'h60
`define RSMC_ADDR_TIMING2 8'h61
`define RSMC_ADDR_CONFIG 8'h62
`define RSMC_ADDR_INT_STAT 8'h70
`define RSMC_ADDR_INT_MASK 8'h71
`define RSMC_ADDR_RX_DATA 8'h72

// ============================================================
// reset values
`define RSMC_RST_TIMING1 8'h22
`define RSMC_RST_TIMING2 8'h02
`define RSMC_RST_CONFIG 8'h00
`define RSMC_RST_INT_MASK 8'h00

// ============================================================
// field positions
`define RSMC_CFG_OVF_BIT 7
`define RSMC_CFG_CLR_BIT 2
`define RSMC_CFG_PHASE_BIT 1
`define RSMC_CFG_POL_BIT 0
`define RSMC_INT_OVF_BIT 0
`define RSMC_INT_FRAME_BIT 1

// ============================================================
// timing
`define RSMC_UNIT_NS 40
`define RSMC_CLK_NS 20
`define RSMC_UNIT_CYC ((`RSMC_UNIT_NS + `RSMC_CLK_NS - 1) / `RSMC_CLK_NS)

`endif

// File: include/rsmc_pkg.sv
// types shared by the remote spi master configuration block
// assumes nothing beyond a systemverilog compiler
package rsmc_pkg;

	// ============================================================
	// carriers
	typedef struct packed {
		logic clk;
		logic ss_n;
		logic mosi;
	} rsmc_link_s;

	typedef struct packed {
		logic sclk;
		logic ss_n;
		logic mosi;
	} rsmc_spi_s;

	// ============================================================
	// engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SS_WAIT,
		ST_SETUP,
		ST_ACTIVE,
		ST_PARK
	} rsmc_state_e;

	typedef logic [5:0] rsmc_cnt_t;

endpackage

// File: rtl/rsmc_top.sv
// remote spi master: regenerates link spi bits on the local spi bus, with config registers
// assumes link and miso pins are asynchronous to CLK_SYS and the link clock is far slower
`include "rsmc_consts.svh"

module rsmc_top (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [7:0] RD_DATA,
	input wire rsmc_pkg::rsmc_link_s LINK_IN,
	output rsmc_pkg::rsmc_spi_s SPI_OUT,
	input wire logic SPI_MISO,
	output logic IRQ
);
	import rsmc_pkg::*;

	// ============================================================
	// helpers
	function automatic rsmc_cnt_t cyc(input logic [3:0] field);
		cyc = rsmc_cnt_t'((field + 5'd1) * `RSMC_UNIT_CYC);
	endfunction

	// ============================================================
	// input synchronisers: three stages, change accepted when stages two and three agree
	logic [3:0] sy1_ff, sy2_ff, sy3_ff, flt_ff, flt_d_ff;
	logic [3:0] raw_in, nxt_flt;
	assign raw_in = {SPI_MISO, LINK_IN.clk, LINK_IN.ss_n, LINK_IN.mosi};
	assign nxt_flt = (sy2_ff & ~(sy2_ff ^ sy3_ff)) | (flt_ff & (sy2_ff ^ sy3_ff));

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			sy1_ff <= 4'h6;
			sy2_ff <= 4'h6;
			sy3_ff <= 4'h6;
			flt_ff <= 4'h6;
			flt_d_ff <= 4'h6;
		end else if (CE) begin
			sy1_ff <= raw_in;
			sy2_ff <= sy1_ff;
			sy3_ff <= sy2_ff;
			flt_ff <= nxt_flt;
			flt_d_ff <= flt_ff;
		end
	end

	wire miso_s = flt_ff[3];
	wire link_clk_rise = flt_ff[2] & ~flt_d_ff[2];
	wire link_ss_n_s = flt_ff[1];
	wire link_ss_rise = flt_ff[1] & ~flt_d_ff[1];
	wire link_mosi_s = flt_ff[0];
	wire link_bit_ev = link_clk_rise & ~link_ss_n_s;

	// ============================================================
	// registers
	logic [7:0] timing1_ff, timing2_ff;
	logic clr_ctl_ff, pol_ff, ovf_ff;
	logic [1:0] int_stat_ff, int_mask_ff;
	logic [7:0] rx_ff, rd_data_ff;

	wire [3:0] hold_fld = timing1_ff[7:4];
	wire [3:0] setup_fld = timing1_ff[3:0];
	wire [3:0] ss_setup_fld = timing2_ff[3:0];

	wire wr_t1 = WR_STB && (ADDR == `RSMC_ADDR_TIMING1);
	wire wr_t2 = WR_STB && (ADDR == `RSMC_ADDR_TIMING2);
	wire wr_cfg = WR_STB && (ADDR == `RSMC_ADDR_CONFIG);
	wire wr_mask = WR_STB && (ADDR == `RSMC_ADDR_INT_MASK);
	wire rd_stat = RD_STB && (ADDR == `RSMC_ADDR_INT_STAT);

	// phase bit is hard zero; reserved bits read zero
	logic [7:0] cfg_rd;
	always_comb begin
		cfg_rd = 8'h00;
		cfg_rd[`RSMC_CFG_OVF_BIT] = ovf_ff;
		cfg_rd[`RSMC_CFG_CLR_BIT] = clr_ctl_ff;
		cfg_rd[`RSMC_CFG_PHASE_BIT] = 1'b0;
		cfg_rd[`RSMC_CFG_POL_BIT] = pol_ff;
	end

	logic [7:0] rd_mux;
	always_comb begin
		case (ADDR)
			`RSMC_ADDR_TIMING1: rd_mux = timing1_ff;
			`RSMC_ADDR_TIMING2: rd_mux = {4'h0, timing2_ff[3:0]};
			`RSMC_ADDR_CONFIG: rd_mux = cfg_rd;
			`RSMC_ADDR_INT_STAT: rd_mux = {6'h00, int_stat_ff};
			`RSMC_ADDR_INT_MASK: rd_mux = {6'h00, int_mask_ff};
			`RSMC_ADDR_RX_DATA: rd_mux = rx_ff;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			timing1_ff <= `RSMC_RST_TIMING1;
			timing2_ff <= `RSMC_RST_TIMING2;
			clr_ctl_ff <= 1'b0;
			pol_ff <= 1'b0;
			int_mask_ff <= 2'h0;
			rd_data_ff <= 8'h00;
		end else if (CE) begin
			if (wr_t1)
				timing1_ff <= WR_DATA;
			if (wr_t2)
				timing2_ff <= {4'h0, WR_DATA[3:0]};
			if (wr_cfg) begin
				clr_ctl_ff <= WR_DATA[`RSMC_CFG_CLR_BIT];
				pol_ff <= WR_DATA[`RSMC_CFG_POL_BIT];
			end
			if (wr_mask)
				int_mask_ff <= WR_DATA[1:0];
			rd_data_ff <= RD_STB ? rd_mux : 8'h00;
		end
	end

	assign RD_DATA = rd_data_ff;

	// ============================================================
	// pending link bit and end of frame
	logic pend_vld_ff, pend_bit_ff, end_pend_ff;
	logic take_bit, take_end;

	// a second bit before the first was launched means the bus cannot keep pace
	wire ovf_ev = link_bit_ev & pend_vld_ff & ~take_bit;
	wire nxt_pend_vld = link_bit_ev | (pend_vld_ff & ~take_bit);
	wire nxt_end_pend = link_ss_rise | (end_pend_ff & ~take_end);
	// set wins over the clear so an overflow in the clearing cycle survives
	wire nxt_ovf = ovf_ev | (ovf_ff & ~clr_ctl_ff);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pend_vld_ff <= 1'b0;
			pend_bit_ff <= 1'b0;
			end_pend_ff <= 1'b0;
			ovf_ff <= 1'b0;
		end else if (CE) begin
			pend_vld_ff <= nxt_pend_vld;
			if (link_bit_ev)
				pend_bit_ff <= link_mosi_s; // newest bit overwrites on overflow
			end_pend_ff <= nxt_end_pend;
			ovf_ff <= nxt_ovf;
		end
	end

	// ============================================================
	// spi engine
	rsmc_state_e state_ff, nxt_state;
	rsmc_cnt_t cnt_ff, nxt_cnt;
	logic sclk_ff, nxt_sclk, ss_n_ff, nxt_ss_n, mosi_ff, nxt_mosi;
	logic sample, frame_ev;
	wire cnt_done = (cnt_ff == rsmc_cnt_t'(1));

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = (cnt_ff > rsmc_cnt_t'(1)) ? cnt_ff - rsmc_cnt_t'(1) : cnt_ff;
		nxt_sclk = sclk_ff;
		nxt_ss_n = ss_n_ff;
		nxt_mosi = mosi_ff;
		take_bit = 1'b0;
		take_end = 1'b0;
		sample = 1'b0;
		frame_ev = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				nxt_sclk = pol_ff;
				nxt_ss_n = 1'b1;
				take_end = end_pend_ff & ~pend_vld_ff;
				if (pend_vld_ff) begin
					nxt_ss_n = 1'b0;
					nxt_cnt = cyc(ss_setup_fld);
					nxt_state = ST_SS_WAIT;
				end
			end
			ST_SS_WAIT: begin
				if (cnt_done) begin
					take_bit = 1'b1;
					nxt_mosi = pend_bit_ff;
					nxt_cnt = cyc(setup_fld);
					nxt_state = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_done) begin
					// leading edge leaves the idle level and samples input
					nxt_sclk = ~pol_ff;
					sample = 1'b1;
					nxt_cnt = cyc(hold_fld);
					nxt_state = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (cnt_done) begin
					nxt_sclk = pol_ff;
					nxt_cnt = cyc(setup_fld);
					nxt_state = ST_PARK;
				end
			end
			ST_PARK: begin
				// data changes only after the inactive clock has been held a full setup time
				if (cnt_done && pend_vld_ff) begin
					take_bit = 1'b1;
					nxt_mosi = pend_bit_ff;
					nxt_cnt = cyc(setup_fld);
					nxt_state = ST_SETUP;
				end else if (cnt_done && end_pend_ff) begin
					take_end = 1'b1;
					frame_ev = 1'b1;
					nxt_ss_n = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_ss_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= ST_IDLE;
			cnt_ff <= rsmc_cnt_t'(1);
			sclk_ff <= 1'b0;
			ss_n_ff <= 1'b1;
			mosi_ff <= 1'b0;
			rx_ff <= 8'h00;
		end else if (CE) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sclk_ff <= nxt_sclk;
			ss_n_ff <= nxt_ss_n;
			mosi_ff <= nxt_mosi;
			if (sample)
				rx_ff <= {rx_ff[6:0], miso_s};
		end
	end

	assign SPI_OUT.sclk = sclk_ff;
	assign SPI_OUT.ss_n = ss_n_ff;
	assign SPI_OUT.mosi = mosi_ff;

	// ============================================================
	// interrupts: sticky status, cleared by reading it; set beats clear
	logic [1:0] int_ev;
	always_comb begin
		int_ev = 2'h0;
		int_ev[`RSMC_INT_OVF_BIT] = ovf_ev;
		int_ev[`RSMC_INT_FRAME_BIT] = frame_ev;
	end

	wire [1:0] nxt_int_stat = int_ev | (int_stat_ff & {2{~rd_stat}});

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N)
			int_stat_ff <= 2'h0;
		else if (CE)
			int_stat_ff <= nxt_int_stat;
	end

	assign IRQ = |(int_stat_ff & int_mask_ff);

endmodule

// File: testbench/rsmc_top_checker.sv
// assertions on the ports of the remote spi master top
// assumes CE is held high by whoever drives the register port
module rsmc_top_checker (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	input wire logic [7:0] RD_DATA,
	input wire rsmc_pkg::rsmc_spi_s SPI_OUT,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 100ps;
	import rsmc_pkg::*;
	logic clr_ff, pol_ff;
	logic [1:0] msk_ff;
	wire logic cfg_wr = WR_STB && CE && ADDR == 8'h62;
	wire logic msk_wr = WR_STB && CE && ADDR == 8'h71;
	// ==========
	// shadow copies of the writable config and mask fields
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			{clr_ff, pol_ff, msk_ff} <= 4'h0;
		end else begin
			if (cfg_wr) {clr_ff, pol_ff} <= {WR_DATA[2], WR_DATA[0]};
			if (msk_wr) msk_ff <= WR_DATA[1:0];
		end
	end
	// ==========
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence idle_2;
		(SPI_OUT.sclk == pol_ff)[*2];
	endsequence
	sequence busy_2;
		(SPI_OUT.sclk != pol_ff && $stable(SPI_OUT.mosi))[*2];
	endsequence
	rd_idle_a: assert property (!$past(RD_STB) |-> RD_DATA == 8'h00)
		else $error("read data not idle");
	cfg_read_a: assert property ($past(RD_STB) && $past(ADDR) == 8'h62
		|-> RD_DATA[2:0] == {$past(clr_ff), 1'b0, $past(pol_ff)}) else $error("config readback");
	idle_level_a: assert property (
		SPI_OUT.ss_n && $past(SPI_OUT.ss_n) && $stable(pol_ff) |-> SPI_OUT.sclk == pol_ff)
		else $error("idle clock level");
	frame_end_a: assert property ($rose(SPI_OUT.ss_n) |-> SPI_OUT.sclk == pol_ff)
		else $error("frame ends mid clock");
	data_setup_a: assert property ($changed(SPI_OUT.mosi) |-> idle_2)
		else $error("data setup short");
	active_width_a: assert property (
		$changed(SPI_OUT.sclk) && SPI_OUT.sclk != pol_ff |-> busy_2) else $error("active short");
	ss_setup_a: assert property ($fell(SPI_OUT.ss_n)
		|-> ($stable(SPI_OUT.sclk) && $stable(SPI_OUT.mosi))[*2]) else $error("select setup");
	irq_mask_a: assert property (IRQ |-> msk_ff != 2'b00)
		else $error("masked interrupt");
endmodule

// File: testbench/rsmc_slave_model.sv
// slave peripheral on the local spi bus: shifts in mosi, answers on miso
// assumes the bench hands over the programmed polarity
module rsmc_slave_model (
	input wire logic pol,
	input wire rsmc_pkg::rsmc_spi_s spi,
	output logic miso,
	output logic [7:0] rx
);
	timeunit 1ns;
	timeprecision 100ps;
	import rsmc_pkg::*;
	initial rx = 8'h00;
	initial miso = 1'b0;
	// ==========
	// capture on the leading edge, launch on the trailing one
	always @(spi.sclk) begin
		if (!spi.ss_n && spi.sclk !== pol) rx = {rx[6:0], spi.mosi};
		else if (!spi.ss_n) miso = ~rx[0];
	end
	// no pull on miso, so a released line must not keep its last level
	always @(posedge spi.ss_n) miso = ~miso;
endmodule

// File: testbench/rsmc_top_tb.sv
// bench of the remote spi master: registers, overflow, interrupt, spi frames
// assumes package, design, slave model and checker compiled first
module rsmc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rsmc_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic WR_STB = 1'b0;
	logic RD_STB = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [7:0] WR_DATA = 8'h00;
	logic [7:0] RD_DATA, rx;
	logic SPI_MISO, IRQ;
	logic pol = 1'b0;
	rsmc_link_s LINK_IN = 3'b110;
	rsmc_spi_s SPI_OUT;
	logic [31:0] seed = 32'h7970;
	logic [7:0] ra [5] = '{8'h60, 8'h61, 8'h62, 8'h71, 8'h7f};
	logic [7:0] rv [5] = '{8'h22, 8'h02, 8'h00, 8'h00, 8'h00};
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	rsmc_top DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(1'b1), .ADDR(ADDR), .WR_DATA(WR_DATA),
		.WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .LINK_IN(LINK_IN),
		.SPI_OUT(SPI_OUT), .SPI_MISO(SPI_MISO), .IRQ(IRQ));
	rsmc_slave_model SLV (.pol(pol), .spi(SPI_OUT), .miso(SPI_MISO), .rx(rx));
	// ==========
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [7:0] cfg(input logic f, input logic [7:0] v);
		return {f, 4'h0, v[2], 1'b0, v[0]};
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CLK_SYS);
		WR_STB <= 1'b1;
		ADDR <= a;
		WR_DATA <= v;
		@(posedge CLK_SYS);
		WR_STB <= 1'b0;
		if (a == 8'h62) pol = v[0];
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge CLK_SYS);
		RD_STB <= 1'b1;
		ADDR <= a;
		@(posedge CLK_SYS);
		RD_STB <= 1'b0;
		#1 chk(RD_DATA, e);
	endtask
	// link clock of 160 ns, parked high between frames, off the system edges
	task automatic frame(input logic [7:0] v);
		#7 LINK_IN.ss_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#80 LINK_IN.clk <= 1'b0;
			LINK_IN.mosi <= v[i];
			#80 LINK_IN.clk <= 1'b1;
		end
		#80 LINK_IN.ss_n <= 1'b1;
		repeat (10) @(posedge CLK_SYS);
		for (int k = 0; k < 400 && SPI_OUT.ss_n !== 1'b1; k++) @(posedge CLK_SYS);
		repeat (4) @(posedge CLK_SYS);
	endtask
	task print_verdict;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ==========
	always #10 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			print_verdict;
		end
	end
	initial begin
		repeat (20) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		for (int i = 0; i < 5; i++) rdc(ra[i], rv[i]);
		rdc(8'h72, 8'h00);
		repeat (4) begin
			seed = xs(seed);
			wr(8'h62, seed[7:0]);
			rdc(8'h62, cfg(1'b0, seed[7:0]));
		end
		// default timing is slower than the link bit, so this frame overflows
		wr(8'h62, 8'h00);
		wr(8'h71, 8'h01);
		seed = xs(seed);
		frame(seed[7:0]);
		rdc(8'h62, cfg(1'b1, 8'h00));
		chk({7'h00, IRQ}, 8'h01);
		rdc(8'h70, 8'h03);
		chk({7'h00, IRQ}, 8'h00);
		wr(8'h60, 8'h00);
		for (int p = 0; p < 2; p++) begin
			seed = xs(seed);
			wr(8'h62, {7'h00, p[0]});
			frame(seed[7:0]);
			chk(rx, seed[7:0]);
			rdc(8'h62, cfg(1'b1, {7'h00, p[0]}));
		end
		wr(8'h62, 8'h04);
		rdc(8'h62, cfg(1'b0, 8'h04));
		wr(8'h62, 8'h00);
		rdc(8'h62, 8'h00);
		print_verdict;
	end
endmodule

bind rsmc_top rsmc_top_checker CHK (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .ADDR(ADDR),
	.WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
	.SPI_OUT(SPI_OUT), .IRQ(IRQ));
